// [rtl/serial_frame_pkg.sv]
// Package: register map, mode fields, status bits and frame helpers
package serial_frame_pkg;

   // Register byte offsets
   localparam logic [4:0] MODE_OFS   = 5'h00;
   localparam logic [4:0] TXDATA_OFS = 5'h04;
   localparam logic [4:0] RXDATA_OFS = 5'h08;
   localparam logic [4:0] STATUS_OFS = 5'h0C;
   localparam logic [4:0] MASK_OFS   = 5'h10;
   localparam logic [4:0] CTRL_OFS   = 5'h14;

   // Mode register field positions
   localparam int unsigned MODE_SYNC_BIT  = 7;
   localparam int unsigned MODE_CHAR7_BIT = 6;
   localparam int unsigned MODE_PAREN_BIT = 5;
   localparam int unsigned MODE_PODD_BIT  = 4;
   localparam int unsigned MODE_STOP2_BIT = 3;
   localparam int unsigned MODE_MULTI_BIT = 2;
   localparam int unsigned MODE_PRE_HI    = 1;
   localparam int unsigned MODE_PRE_LO    = 0;

   // Control register positions
   localparam int unsigned CTRL_MPB_BIT  = 0;
   localparam int unsigned CTRL_TXB_BIT  = 4;
   localparam int unsigned CTRL_RXB_BIT  = 5;
   localparam int unsigned CTRL_PEND_BIT = 6;

   // Status bits, shared by the mask register
   localparam int unsigned ST_TX_DONE = 0;
   localparam int unsigned ST_RX_FULL = 1;
   localparam int unsigned ST_PAR_ERR = 2;
   localparam int unsigned ST_FRM_ERR = 3;
   localparam int unsigned STATUS_W   = 4;

   // Reset values
   localparam logic [7:0] MODE_RESET   = 8'h00;
   localparam logic [7:0] TXHOLD_RESET = 8'hFF;
   localparam logic [8:0] RXDATA_RESET = 9'h000;

   // Prescaler terminal counts for divide by 1, 4, 16, 64
   localparam logic [5:0] PRE_LIM_1  = 6'h00;
   localparam logic [5:0] PRE_LIM_4  = 6'h03;
   localparam logic [5:0] PRE_LIM_16 = 6'h0F;
   localparam logic [5:0] PRE_LIM_64 = 6'h3F;

   // Bits in one clocked character
   localparam logic [3:0] SYNC_BITS = 4'h8;

   // Decoded frame format
   typedef struct packed {
      logic sync;
      logic len7;
      logic par_on;
      logic par_odd;
      logic stop2;
      logic multi_on;
   } frame_fmt_type;

   // Mode byte to effective format; clocked mode masks async-only fields
   function automatic frame_fmt_type decode_fmt(input logic [7:0] m);
      frame_fmt_type f;
      f.sync    = m[MODE_SYNC_BIT];
      f.len7    = !f.sync && m[MODE_CHAR7_BIT];
      f.multi_on = !f.sync && m[MODE_MULTI_BIT];
      f.par_on  = !f.sync && !f.multi_on && m[MODE_PAREN_BIT];
      f.par_odd = f.par_on && m[MODE_PODD_BIT];
      f.stop2   = !f.sync && m[MODE_STOP2_BIT];
      return f;
   endfunction

endpackage

// [rtl/baud_prescaler.sv]
// Baud clock prescaler: one-cycle tick at the selected divide ratio
`timescale 1ns/1ps
module baud_prescaler (
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       arst_n_in,
   // Divide select code
   input  wire logic [1:0] prescale_sel_in,
   // Tick output
   output logic            tick_out
);

   logic [5:0] cnt_q;
   logic [5:0] lim_w;
   logic       hit_w;

   // Code to terminal count
   assign lim_w = (prescale_sel_in == 2'h0) ? serial_frame_pkg::PRE_LIM_1  :
                  (prescale_sel_in == 2'h1) ? serial_frame_pkg::PRE_LIM_4  :
                  (prescale_sel_in == 2'h2) ? serial_frame_pkg::PRE_LIM_16 :
                                              serial_frame_pkg::PRE_LIM_64;
   // Also wraps at once if the code shrinks mid-count
   assign hit_w = (cnt_q >= lim_w);

   // Free-running divider
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q    <= 6'h00;
         tick_out <= 1'b0;
      end else begin
         cnt_q    <= hit_w ? 6'h00 : cnt_q + 6'h01;
         tick_out <= hit_w;
      end
   end

   div64_gap_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (tick_out && prescale_sel_in == 2'h3 && $stable(prescale_sel_in)) |=> !tick_out [*8])
      else $error("prescaler tick too early at divide 64");

   div4_cov: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      (prescale_sel_in == 2'h1 && tick_out) ##4 tick_out);

endmodule // baud_prescaler

// [rtl/serial_frame_core.sv]
// Serial port core: mode register, frame transmitter, frame receiver
//
// Summary of operation
// - Mode bit 7 picks asynchronous (0) or clocked (1) operation.
// - Async bit 6 picks eight (0) or seven (1) data bits; clocked is eight.
// - Seven-bit characters never shift out bit 7 of the holding register.
// - Async parity enable adds a parity bit on send and checks it on receive.
// - Clocked mode never adds or checks parity.
// - Even sense: data plus parity carry an even count of ones; else error.
// - Odd sense: data plus parity carry an odd count of ones; else error.
// - Parity sense matters only with async parity enabled.
// - Async send ends with one stop bit of 1, or two when stop bit set.
// - Clocked mode sends no stop bits; stop setting ignored.
// - Receiver checks only the first stop bit position for framing.
// - Second position: 1 is a stop bit, 0 starts the next character.
// - Mode register reads and writes are accepted at any time.
// - Async multiprocessor format overrides parity settings; clocked ignores it.
// - Prescale code 00/01/10/11 divides the clock by 1/4/16/64.
`timescale 1ns/1ps
module serial_frame_core (
   // Clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        arst_n_in,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   // Serial pins
   input  wire logic        rxd_in,
   output logic             txd_out,
   output logic             sclk_out,
   // Interrupt
   output logic             irq_out
);

   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} tx_state_type;
   typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_ACTIVE = 2'b10} rx_state_type;

   // Frame image, LSB first on the line; unused positions stay at 1
   function automatic logic [11:0] build_frame(input serial_frame_pkg::frame_fmt_type f,
                                               input logic [7:0] d, input logic mpb);
      logic [11:0] fr;
      logic [7:0]  de;
      logic        slot;
      de   = f.len7 ? {1'b0, d[6:0]} : d;
      slot = f.multi_on ? mpb : (^de ^ f.par_odd);
      fr   = 12'hFFF;
      if (f.sync) begin
         fr[7:0] = d;
      end else begin
         fr[0]   = 1'b0;
         fr[8:1] = f.len7 ? {1'b1, d[6:0]} : d;
         if (f.par_on || f.multi_on) begin
            fr[f.len7 ? 8 : 9] = slot;
         end
      end
      return fr;
   endfunction

   // Bit count of a frame; the receiver passes stop2 cleared
   function automatic logic [3:0] frame_len(input serial_frame_pkg::frame_fmt_type f);
      logic [3:0] n;
      if (f.sync) begin
         n = serial_frame_pkg::SYNC_BITS;
      end else begin
         n = f.len7 ? 4'h9 : 4'hA;
         if (f.par_on || f.multi_on) begin
            n = n + 4'h1;
         end
         if (f.stop2) begin
            n = n + 4'h1;
         end
      end
      return n;
   endfunction

   // Registers
   logic [7:0]                     mode_q;
   logic [7:0]                     tx_hold_q;
   logic [8:0]                     rx_data_q;
   logic [serial_frame_pkg::STATUS_W-1:0] status_q;
   logic [serial_frame_pkg::STATUS_W-1:0] mask_q;
   logic                           mpb_q;
   logic                           ack_q;
   logic                           tx_pend_q;
   tx_state_type                   tx_state_q;
   rx_state_type                   rx_state_q;
   serial_frame_pkg::frame_fmt_type tx_fmt_q;
   serial_frame_pkg::frame_fmt_type rx_fmt_q;
   logic [10:0]                    tx_shift_q;
   logic [3:0]                     tx_left_q;
   logic                           tx_phase_q;
   logic [10:0]                    rx_bits_q;
   logic [3:0]                     rx_cnt_q;
   logic                           rx_phase_q;

   // Decode wires
   serial_frame_pkg::frame_fmt_type fmt_w;
   serial_frame_pkg::frame_fmt_type rx_nostop_w;
   logic                           tick_w;
   logic                           wr_w;
   logic                           sel_mode_w;
   logic                           sel_tx_w;
   logic                           sel_st_w;
   logic                           sel_mask_w;
   logic                           sel_ctrl_w;
   logic [31:0]                    rd_mux_w;
   logic [11:0]                    frame_w;
   logic                           tx_load_w;
   logic                           tx_bit_end_w;
   logic                           tx_end_w;
   logic                           rx_start_w;
   logic                           rx_samp_w;
   logic                           rx_stop_w;
   logic [3:0]                     rx_last_w;
   logic [7:0]                     rx_byte_w;
   logic                           rx_slot_w;
   logic                           par_bad_w;
   logic                           sync_samp_w;
   logic                           sync_done_w;
   logic [serial_frame_pkg::STATUS_W-1:0] events_w;
   logic [serial_frame_pkg::STATUS_W-1:0] clear_w;

   // Baud tick from the prescale field
   baud_prescaler u_prescaler (
      .sys_clk_in      (sys_clk_in),
      .arst_n_in       (arst_n_in),
      .prescale_sel_in (mode_q[serial_frame_pkg::MODE_PRE_HI:serial_frame_pkg::MODE_PRE_LO]),
      .tick_out        (tick_w)
   );

   // Bus decode; a write lands at the edge where waitrequest is low
   assign fmt_w      = serial_frame_pkg::decode_fmt(mode_q);
   assign wr_w       = avs_write_in && ack_q;
   assign sel_mode_w = (avs_address_in == serial_frame_pkg::MODE_OFS);
   assign sel_tx_w   = (avs_address_in == serial_frame_pkg::TXDATA_OFS);
   assign sel_st_w   = (avs_address_in == serial_frame_pkg::STATUS_OFS);
   assign sel_mask_w = (avs_address_in == serial_frame_pkg::MASK_OFS);
   assign sel_ctrl_w = (avs_address_in == serial_frame_pkg::CTRL_OFS);
   assign clear_w    = (wr_w && sel_st_w) ? avs_writedata_in[serial_frame_pkg::STATUS_W-1:0]
                                          : '0;

   // Read mux; unmapped addresses read zero
   assign rd_mux_w =
      sel_mode_w ? {24'h00_0000, mode_q} :
      sel_tx_w   ? {24'h00_0000, tx_hold_q} :
      (avs_address_in == serial_frame_pkg::RXDATA_OFS) ? {23'h00_0000, rx_data_q} :
      sel_st_w   ? {28'h000_0000, status_q} :
      sel_mask_w ? {28'h000_0000, mask_q} :
      sel_ctrl_w ? {25'h000_0000, tx_pend_q, rx_state_q == RX_ACTIVE,
                    tx_state_q == TX_SHIFT, 3'h0, mpb_q} : 32'h0000_0000;

   // Transmit timing: each bit is two ticks; in clocked mode line clock low then high, async holds it high
   assign frame_w      = build_frame(fmt_w, tx_hold_q, mpb_q);
   assign tx_load_w    = tx_pend_q && (tx_state_q == TX_IDLE);
   assign tx_bit_end_w = (tx_state_q == TX_SHIFT) && tick_w && tx_phase_q;
   assign tx_end_w     = tx_bit_end_w && (tx_left_q == 4'h0);

   // Async receive: stop2 dropped so only the first stop is sampled
   assign rx_nostop_w = '{sync: rx_fmt_q.sync, len7: rx_fmt_q.len7, par_on: rx_fmt_q.par_on,
                          par_odd: rx_fmt_q.par_odd, stop2: 1'b0, multi_on: rx_fmt_q.multi_on};
   assign rx_last_w   = frame_len(rx_nostop_w) - 4'h1;
   assign rx_start_w  = (rx_state_q == RX_IDLE) && !fmt_w.sync && tick_w && !rxd_in;
   assign rx_samp_w   = (rx_state_q == RX_ACTIVE) && tick_w && rx_phase_q;
   assign rx_stop_w   = rx_samp_w && (rx_cnt_q == rx_last_w);
   assign rx_byte_w   = rx_fmt_q.len7 ? {1'b0, rx_bits_q[7:1]} : rx_bits_q[8:1];
   assign rx_slot_w   = rx_fmt_q.len7 ? rx_bits_q[8] : rx_bits_q[9];
   assign par_bad_w   = rx_fmt_q.par_on && (^rx_byte_w ^ rx_slot_w ^ rx_fmt_q.par_odd);

   // Clocked receive samples on the rising line clock of own transmission
   assign sync_samp_w = (tx_state_q == TX_SHIFT) && tx_fmt_q.sync && tick_w && !tx_phase_q
                        && (rx_state_q == RX_IDLE);
   assign sync_done_w = sync_samp_w && (rx_cnt_q == 4'h7);

   // Status events
   assign events_w[serial_frame_pkg::ST_TX_DONE] = tx_end_w;
   assign events_w[serial_frame_pkg::ST_RX_FULL] = rx_stop_w || sync_done_w;
   assign events_w[serial_frame_pkg::ST_PAR_ERR] = rx_stop_w && par_bad_w;
   assign events_w[serial_frame_pkg::ST_FRM_ERR] = rx_stop_w && !rxd_in;

   // Bus handshake: one wait cycle, read data registered with it
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ack_q               <= 1'b0;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0000_0000;
      end else begin
         ack_q               <= (avs_read_in || avs_write_in) && !ack_q;
         avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_q);
         avs_readdata_out    <= rd_mux_w;
      end
   end

   // Software registers; no interlock with the shifters
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mode_q    <= serial_frame_pkg::MODE_RESET;
         tx_hold_q <= serial_frame_pkg::TXHOLD_RESET;
         mask_q    <= '0;
         mpb_q     <= 1'b0;
         tx_pend_q <= 1'b0;
      end else begin
         if (wr_w && sel_mode_w) begin
            mode_q <= avs_writedata_in[7:0];
         end
         if (wr_w && sel_tx_w) begin
            tx_hold_q <= avs_writedata_in[7:0];
         end
         if (wr_w && sel_mask_w) begin
            mask_q <= avs_writedata_in[serial_frame_pkg::STATUS_W-1:0];
         end
         if (wr_w && sel_ctrl_w) begin
            mpb_q <= avs_writedata_in[serial_frame_pkg::CTRL_MPB_BIT];
         end
         // A new write in the load cycle keeps the pending flag set
         tx_pend_q <= (tx_pend_q && !tx_load_w) || (wr_w && sel_tx_w);
      end
   end

   // Sticky status, set beats clear; level interrupt
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         status_q <= '0;
         irq_out  <= 1'b0;
      end else begin
         status_q <= (status_q & ~clear_w) | events_w;
         irq_out  <= |(status_q & mask_q);
      end
   end

   // Transmitter; format frozen at load, but a mode write to the prescale field still retimes a frame in flight
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_state_q <= TX_IDLE;
         tx_fmt_q   <= '0;
         tx_shift_q <= 11'h7FF;
         tx_left_q  <= 4'h0;
         tx_phase_q <= 1'b0;
         txd_out    <= 1'b1;
         sclk_out   <= 1'b1;
      end else if (tx_load_w) begin
         tx_state_q <= TX_SHIFT;
         tx_fmt_q   <= fmt_w;
         txd_out    <= frame_w[0];
         tx_shift_q <= frame_w[11:1];
         tx_left_q  <= frame_len(fmt_w) - 4'h1;
         tx_phase_q <= 1'b0;
         sclk_out   <= !fmt_w.sync;
      end else if (tx_end_w) begin
         tx_state_q <= TX_IDLE;
         txd_out    <= 1'b1;
         sclk_out   <= 1'b1;
      end else if ((tx_state_q == TX_SHIFT) && tick_w) begin
         tx_phase_q <= !tx_phase_q;
         sclk_out   <= !tx_fmt_q.sync || !tx_phase_q;
         if (tx_phase_q) begin
            txd_out    <= tx_shift_q[0];
            tx_shift_q <= {1'b1, tx_shift_q[10:1]};
            tx_left_q  <= tx_left_q - 4'h1;
         end
      end
   end

   // Receiver; a false start bit drops back to idle
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rx_state_q <= RX_IDLE;
         rx_fmt_q   <= '0;
         rx_bits_q  <= 11'h000;
         rx_cnt_q   <= 4'h0;
         rx_phase_q <= 1'b0;
         rx_data_q  <= serial_frame_pkg::RXDATA_RESET;
      end else if (tx_load_w && fmt_w.sync && (rx_state_q == RX_IDLE)) begin
         rx_cnt_q <= 4'h0;
      end else if (sync_samp_w) begin
         rx_bits_q[rx_cnt_q + 4'h1] <= rxd_in;
         rx_cnt_q <= rx_cnt_q + 4'h1;
         if (sync_done_w) begin
            rx_data_q <= {1'b0, rxd_in, rx_bits_q[7:1]};
         end
      end else if (rx_start_w) begin
         rx_state_q <= RX_ACTIVE;
         rx_fmt_q   <= fmt_w;
         rx_cnt_q   <= 4'h0;
         rx_phase_q <= 1'b1;
      end else if ((rx_state_q == RX_ACTIVE) && tick_w) begin
         rx_phase_q <= !rx_phase_q;
         if (rx_phase_q) begin
            rx_bits_q[rx_cnt_q] <= rxd_in;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if ((rx_cnt_q == 4'h0) && rxd_in) begin
               rx_state_q <= RX_IDLE;
            end
            if (rx_stop_w) begin
               rx_state_q <= RX_IDLE;
               rx_data_q  <= {rx_fmt_q.multi_on && rx_slot_w, rx_byte_w};
            end
         end
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   mode_write_a: assert property ((wr_w && sel_mode_w) |=>
      mode_q == $past(avs_writedata_in[7:0]))
      else $error("mode write not taken");
   seven_bit_a: assert property ((tx_load_w && fmt_w.len7 && !fmt_w.par_on &&
      !fmt_w.multi_on) |=> tx_shift_q[7])
      else $error("bit 7 shifted in seven-bit mode");
   stop_level_a: assert property ((tx_end_w && !tx_fmt_q.sync) |-> txd_out)
      else $error("stop bit not high");
   sync_length_a: assert property ((tx_load_w && fmt_w.sync) |=>
      tx_left_q == 4'h7 && txd_out == $past(tx_hold_q[0]))
      else $error("clocked frame length wrong");
   even_parity_a: assert property ((tx_load_w && fmt_w.par_on && !fmt_w.par_odd) |=>
      (tx_fmt_q.len7 ? ^tx_shift_q[7:0] : ^tx_shift_q[8:0]) == 1'b0)
      else $error("even parity wrong");
   odd_parity_a: assert property ((tx_load_w && fmt_w.par_on && fmt_w.par_odd) |=>
      (tx_fmt_q.len7 ? ^tx_shift_q[7:0] : ^tx_shift_q[8:0]) == 1'b1)
      else $error("odd parity wrong");
   no_parity_a: assert property ((rx_stop_w && !rx_fmt_q.par_on) |=>
      status_q[serial_frame_pkg::ST_PAR_ERR] == $past(status_q[serial_frame_pkg::ST_PAR_ERR]))
      else $error("parity flagged while disabled");
   framing_a: assert property ((rx_stop_w && !rxd_in) |=>
      status_q[serial_frame_pkg::ST_FRM_ERR] && rx_state_q == RX_IDLE)
      else $error("framing error missed");
   restart_a: assert property (rx_start_w |=> rx_state_q == RX_ACTIVE &&
      rx_cnt_q == 4'h0 && rx_phase_q)
      else $error("start bit not followed");
   irq_level_a: assert property (|(status_q & mask_q) |=> irq_out)
      else $error("interrupt not raised");

   async_frame_cov: cover property (tx_load_w && !fmt_w.sync ##[1:600] tx_end_w);
   sync_rx_cov: cover property (sync_done_w);
   par_err_cov: cover property (rx_stop_w && par_bad_w);
   irq_cov: cover property ($rose(irq_out));

endmodule // serial_frame_core

// [testbench/serial_far_end.sv]
// Far-side serial device model: frame capture on txd, frame send on rxd
`timescale 1ns/1ps
module serial_far_end (
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       arst_n_in,
   // Line from the port and clocked-mode select
   input  wire logic       txd_in,
   input  wire logic       sclk_in,
   input  wire logic       sync_mode_in,
   // Line to the port and captures
   output logic            rxd_out,
   output logic [9:0]      cap_bits_out,
   output logic [7:0]      sync_bits_out,
   output int              cap_count_out,
   output int              sclk_rises_out
);
   logic [4:0] cnt_q;
   logic       sclk_q;
   initial rxd_out = 1'b1;
   // Capture: ten bits after start at one clock per tick; clocked bits on sclk rise
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q <= 5'h00;
         sclk_q <= 1'b1;
         cap_count_out <= 0;
         sclk_rises_out <= 0;
      end else begin
         sclk_q <= sclk_in;
         if (sclk_in && !sclk_q) begin
            sync_bits_out <= {txd_in, sync_bits_out[7:1]};
            sclk_rises_out <= sclk_rises_out + 1;
         end
         if (cnt_q == 5'h00) begin
            if (!txd_in && !sync_mode_in) cnt_q <= 5'h01;
         end else begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q[0] && cnt_q >= 5'h03) cap_bits_out[4'((cnt_q - 5'h03) >> 1)] <= txd_in;
            if (cnt_q == 5'h15) begin
               cnt_q <= 5'h00;
               cap_count_out <= cap_count_out + 1;
            end
         end
      end
   end
   // Bits LSB first, two clocks each; line returns to idle high after
   task automatic send_line(input logic [19:0] bits, input int n);
      @(posedge sys_clk_in);
      for (int i = 0; i < n; i++) begin
         rxd_out <= bits[i];
         repeat (2) @(posedge sys_clk_in);
      end
      rxd_out <= 1'b1;
   endtask
endmodule // serial_far_end

// [testbench/serial_frame_format_config_bench.sv]
// Self-checking bench for the serial port core
`timescale 1ns/1ps
module serial_frame_format_config_bench;
   logic        sys_clk_in, arst_n_in, rd, wr, rxd, txd, sclk, irq, wreq, sync_md;
   logic [4:0]  adr;
   logic [31:0] wd, rdata, v;
   logic [9:0]  cap;
   logic [7:0]  sbits;
   int          num_errors, comparisons, ncap, nrise;
   serial_frame_core serial_frame_core_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .rxd_in(rxd), .txd_out(txd),
      .sclk_out(sclk), .irq_out(irq));
   serial_far_end serial_far_end_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
      .txd_in(txd), .sclk_in(sclk), .sync_mode_in(sync_md), .rxd_out(rxd),
      .cap_bits_out(cap), .sync_bits_out(sbits), .cap_count_out(ncap),
      .sclk_rises_out(nrise));
   // Clock at 8 ns
   initial begin
      sys_clk_in = 1'b0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         num_errors++;
         $display("wrong value wait expected done seen timeout");
         tally_and_finish;
      end
   endtask
   // One bus cycle; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_in);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      v = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      guard(n, 20);
   endtask
   task automatic tx_idle;
      int n;
      n = 0;
      do begin
         bus(1'b0, 5'h14, 32'h0000_0000);
         n++;
      end while ((v[4] | v[6]) && n < 1000);
      guard(n, 1000);
   endtask
   // Expected ten line bits after start; slot is mp bit (ctrl holds 1) or parity
   function automatic logic [9:0] exp_line(input logic [7:0] m, input logic [7:0] d);
      logic [9:0] e;
      int k;
      e = 10'h3FF;
      k = m[6] ? 7 : 8;
      for (int i = 0; i < k; i++) e[i] = d[i];
      if (m[2]) e[k] = 1'b1;
      else if (m[5]) e[k] = ^(d & (m[6] ? 8'h7F : 8'hFF)) ^ m[4];
      return e;
   endfunction
   task automatic t_reset;
      bus(1'b0, 5'h00, 32'h0000_0000);
      check("mode reset", v, 32'h0000_0000);
      bus(1'b0, 5'h1C, 32'h0000_0000);
      check("unmapped", v, 32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic t_tx;
      logic [7:0] md[8] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h60, 8'h24, 8'h08, 8'h40};
      logic [7:0] dt[8] = '{8'hA5, 8'h3C, 8'hA7, 8'hA7, 8'h80, 8'h5A, 8'h0F, 8'h7F};
      int old, n;
      bus(1'b1, 5'h14, 32'h0000_0001);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 5'h00, {24'h0000_00, md[i]});
         old = ncap;
         bus(1'b1, 5'h04, {24'h0000_00, dt[i]});
         bus(1'b0, 5'h00, 32'h0000_0000);
         check("mode while busy", v, {24'h0000_00, md[i]});
         n = 0;
         while (ncap == old && n < 200) begin
            @(posedge sys_clk_in);
            n++;
         end
         guard(n, 200);
         check("tx frame", {22'h0, cap}, {22'h0, exp_line(md[i], dt[i])});
         tx_idle();
      end
      $display("test tx formats done");
   endtask
   task automatic t_sync;
      int old, n;
      sync_md <= 1'b1;
      bus(1'b1, 5'h00, 32'h0000_00E8);
      old = nrise;
      bus(1'b1, 5'h04, 32'h0000_00C3);
      tx_idle();
      repeat (8) @(posedge sys_clk_in);
      check("sync data", {24'h0, sbits}, 32'h0000_00C3);
      check("sync clocks", nrise - old, 32'h0000_0008);
      bus(1'b1, 5'h00, 32'h0000_0000);
      sync_md <= 1'b0;
      $display("test clocked done");
   endtask
   // Receive one line pattern, then status, data and interrupt
   task automatic rx_case(input logic [7:0] m, input logic [19:0] b, input int n,
                          input logic [7:0] d, input logic [3:0] st);
      bus(1'b1, 5'h00, {24'h0000_00, m});
      bus(1'b1, 5'h0C, 32'h0000_000F);
      serial_far_end_i.send_line(b, n);
      repeat (6) @(posedge sys_clk_in);
      bus(1'b0, 5'h0C, 32'h0000_0000);
      check("rx status", v & 32'h0000_000E, {28'h0, st});
      bus(1'b0, 5'h08, 32'h0000_0000);
      check("rx data", v & 32'h0000_00FF, {24'h0, d});
      check("irq set", {31'h0, irq}, 32'h0000_0001);
      bus(1'b1, 5'h0C, 32'h0000_000F);
      repeat (2) @(posedge sys_clk_in);
      check("irq clear", {31'h0, irq}, 32'h0000_0000);
   endtask
   task automatic t_rx;
      bus(1'b1, 5'h10, 32'h0000_0002);
      rx_case(8'h20, {9'h0, 1'b1, 1'b0, 8'hA5, 1'b0}, 11, 8'hA5, 4'h2);
      rx_case(8'h20, {9'h0, 1'b1, 1'b1, 8'hA5, 1'b0}, 11, 8'hA5, 4'h6);
      rx_case(8'h30, {9'h0, 1'b1, 1'b1, 8'h3C, 1'b0}, 11, 8'h3C, 4'h2);
      rx_case(8'h30, {9'h0, 1'b1, 1'b0, 8'h3C, 1'b0}, 11, 8'h3C, 4'h6);
      rx_case(8'h00, {10'h0, 1'b0, 8'hA5, 1'b0}, 10, 8'hA5, 4'hA);
      rx_case(8'h08, {1'b1, 8'h66, 1'b0, 1'b1, 8'h11, 1'b0}, 20, 8'h66, 4'h2);
      rx_case(8'h60, {10'h0, 1'b1, 1'b1, 7'h25, 1'b0}, 10, 8'h25, 4'h2);
      rx_case(8'h24, {9'h0, 1'b1, 1'b1, 8'h5A, 1'b0}, 11, 8'h5A, 4'h2);
      $display("test rx done");
   endtask
   // First data bit lasts two ticks; start may be short as load is not tick aligned
   task automatic t_prescale;
      int n;
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 5'h00, c);
         bus(1'b1, 5'h04, 32'h0000_0001);
         n = 0;
         while (txd !== 1'b0 && n < 500) begin
            @(posedge sys_clk_in);
            n++;
         end
         guard(n, 500);
         n = 0;
         while (txd === 1'b0 && n < 500) begin
            @(posedge sys_clk_in);
            n++;
         end
         guard(n, 500);
         n = 0;
         while (txd === 1'b1 && n < 500) begin
            n++;
            @(posedge sys_clk_in);
         end
         check("bit length", n, 2 << (2 * c));
         tx_idle();
      end
      $display("test prescale done");
   endtask
   // Main sequence
   initial begin
      {rd, wr, sync_md} = 3'b000;
      adr = 5'h00;
      wd = 32'h0000_0000;
      arst_n_in = 1'b0;
      repeat (10) @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      t_reset();
      t_tx();
      t_sync();
      t_rx();
      t_prescale();
      tally_and_finish();
   end
endmodule // serial_frame_format_config_bench
